// ==== verilog/dsb_pkg.sv ====
/*
 * Shared constants, types and the command classifier for the debug
 * status and breakpoint block.
 * Assumes nothing of its surroundings; every user names items with
 * the dsb_pkg:: scope.
 */
package dsb_pkg;

	// Field widths
	localparam int CODE_W = 8;
	localparam int MATCH_W = 16;
	localparam int ADDR_W = 14;
	localparam int SCR_W = 8;
	localparam int LEN_W = 5;

	// Serial frame lengths in bits
	localparam logic [4:0] LEN_BYTE = 5'h08;
	localparam logic [4:0] LEN_WORD = 5'h10;
	localparam logic [4:0] LEN_NONE = 5'h00;

	// Command codes handled or classed here
	localparam logic [7:0] CMD_BACKGROUND = 8'h90;
	localparam logic [7:0] CMD_STATUS_READ = 8'hE4;
	localparam logic [7:0] CMD_CONTROL_WRITE = 8'hC4;
	localparam logic [7:0] CMD_MATCH_READ = 8'hE2;
	localparam logic [7:0] CMD_MATCH_WRITE = 8'hC2;
	localparam logic [7:0] CMD_GO = 8'h08;
	localparam logic [7:0] CMD_TRACE = 8'h10;

	// Status/control bit positions
	localparam int BIT_PERMIT = 7;
	localparam int BIT_ACTIVE = 6;
	localparam int BIT_BKPT_EN = 5;
	localparam int BIT_FORCE_TAG = 4;
	localparam int BIT_WS = 2;
	localparam int BIT_WSF = 1;

	// Reset values
	localparam logic PERMIT_RST = 1'b0;
	localparam logic BKPT_EN_RST = 1'b0;
	localparam logic FORCE_TAG_RST = 1'b0;
	localparam logic [15:0] MATCH_RST = 16'h0000;
	localparam logic [7:0] SCR_ZERO = 8'h00;

	// Writable control fields, carried as one unit
	typedef struct packed {
		logic permit;
		logic bkpt_en;
		logic force_tag;
	} dsb_ctrl_s;

	// Command framing states
	typedef enum logic [1:0] {
		RX_CODE,
		RX_DATA,
		RX_PASS
	} dsb_rx_e;

	// Command classes
	typedef enum logic [2:0] {
		CLS_LOCAL,
		CLS_MEM,
		CLS_FREE,
		CLS_ACTIVE,
		CLS_NONE
	} dsb_cls_e;

	// Sort a command code into its class
	function automatic dsb_cls_e classify(input logic [7:0] code);
		dsb_cls_e cls;
		cls = CLS_NONE;
		case (code)
			8'h90, 8'hE4, 8'hC4, 8'hE2, 8'hC2: cls = CLS_LOCAL;
			8'hE0, 8'hE1, 8'hC0, 8'hC1: cls = CLS_MEM;
			8'h18: cls = CLS_FREE;
			8'h08, 8'h10, 8'h80, 8'h88, 8'h68, 8'h48,
			8'h6B, 8'h4B, 8'h6F, 8'h4F: cls = CLS_ACTIVE;
			default: cls = CLS_NONE;
		endcase
		return cls;
	endfunction

endpackage

// ==== verilog/dsb_shift.sv ====
/*
 * Serial-in shift register that collects host bits MSB first and
 * pulses done after a chosen number of bits.
 * Assumes bit strobes come from bit-timing logic on the same clock.
 */
`timescale 1ns/1ps
module dsb_shift #(
	parameter int WIDTH = 16,
	parameter int CNT_W = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic clear,
	input wire logic [CNT_W-1:0] length,
	// Bit stream
	input wire logic bit_valid,
	input wire logic bit_in,
	// Result
	output logic [WIDTH-1:0] value,
	output logic done
);

	logic [CNT_W-1:0] count;

	// Earlier bits move up, so the first bit ends as the MSB
	always_ff @(posedge clk) begin
		if (srst) begin
			value <= '0;
		end else if (bit_valid && !clear) begin
			value <= {value[WIDTH-2:0], bit_in};
		end
	end

	// Bit counter; clear drops a half-received frame
	always_ff @(posedge clk) begin
		if (srst || clear) begin
			count <= '0;
			done <= 1'b0;
		end else if (bit_valid && count == length - 1'b1) begin
			count <= '0;
			done <= 1'b1;
		end else if (bit_valid) begin
			count <= count + 1'b1;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
		end
	end

endmodule

// ==== verilog/dsb_bkpt.sv ====
/*
 * Hardware breakpoint: address compare with forced or tagged request.
 * Assumes CPU strobes are on the bus clock and that halted is high
 * while the core sits in active debug mode.
 */
`timescale 1ns/1ps
module dsb_bkpt (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Configuration
	input wire dsb_pkg::dsb_ctrl_s ctrl,
	input wire logic [dsb_pkg::ADDR_W-1:0] match_addr,
	input wire logic halted,
	// CPU activity
	input wire logic [dsb_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic addr_valid,
	input wire logic opcode_fetch,
	input wire logic queue_end,
	input wire logic instr_boundary,
	// Request to enter active debug mode
	output logic break_req
);

	logic hit;
	logic force_pending;
	logic tag;

	// Only the 14 address bits take part in the compare
	assign hit = addr_valid && cpu_addr == match_addr; // R13

	// Forced request waits for the next instruction boundary
	always_ff @(posedge clk) begin
		if (srst || halted || !ctrl.bkpt_en) begin // R04
			force_pending <= 1'b0;
		end else if (ctrl.force_tag && hit) begin // R05
			force_pending <= 1'b1;
		end else if (instr_boundary) begin
			force_pending <= 1'b0;
		end
	end

	// Tag follows the fetched opcode; a newer tag wins over retiring
	always_ff @(posedge clk) begin
		if (srst || halted || !ctrl.bkpt_en) begin // R04
			tag <= 1'b0;
		end else if (!ctrl.force_tag && hit && opcode_fetch) begin // R06
			tag <= 1'b1;
		end else if (queue_end) begin
			tag <= 1'b0;
		end
	end

	// One-cycle request to the mode logic
	always_ff @(posedge clk) begin
		if (srst) begin
			break_req <= 1'b0;
		end else begin
			break_req <= ctrl.bkpt_en && !halted && // R04
				((force_pending && instr_boundary) || // R05
				(tag && queue_end)); // R06
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	force_break_a: assert property ( // R05
		ctrl.bkpt_en && ctrl.force_tag && !halted && force_pending
		&& instr_boundary |=> break_req)
		else $error("forced breakpoint not raised at boundary");

	break_off_a: assert property ( // R04
		!ctrl.bkpt_en |=> !break_req)
		else $error("breakpoint fired while disabled");

endmodule

// ==== verilog/dsb_core.sv ====
/*
 * Debug status/control register, breakpoint match register, active
 * debug mode gating and command classing for the single-wire debug
 * controller.
 * Assumes a bit-timing front end on the same clock that delivers host
 * bits as strobes, asks for target bits, and flags the serial timeout.
 * Memory access commands are executed by another unit that receives
 * the forwarded code and reports when it has consumed the frame.
 */
`timescale 1ns/1ps
// Contract
// R01: Permit bit low blocks entering debug mode
// R02: Permit bit sticks at one until reset
// R03: Active bit reads one in debug mode
// R04: Breakpoint logic off when enable is low
// R05: Forced match halts at next instruction boundary
// R06: Tagged opcode halts on reaching queue end
// R07: Wait/stop bit shows wait, stop, or wakeup
// R08: In wait/stop only background must work
// R09: Background command wakes CPU into debug mode
// R10: Host confirms active bit after forcing entry
// R11: Failure bit set when access hits wait/stop
// R12: Host recovers failure via background and retry
// R13: Sixteen-bit match register, fourteen bits compared
// R14: Match register access allowed while running
// R15: Intrusive commands only in debug mode
// R16: Codes and data travel MSB first
// R17: Status register only via serial commands
// R18: Host sets permit before code may stop
// R19: Permit locked in debug mode; status unwritable
// R20: E4 reads status, C4 writes eight bits
// R21: Code 90 enters only when permit set
// R22: Bits three and zero read zero
module dsb_core (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// Serial front end
	input wire logic RX_BIT_VALID,
	input wire logic RX_BIT,
	input wire logic TX_BIT_REQ,
	input wire logic SOFT_RESET,
	output logic TX_BIT,
	output logic TX_BUSY,
	// Forwarded commands
	input wire logic FWD_DONE,
	output logic FWD_VALID,
	output logic [7:0] FWD_CODE,
	output logic CMD_REJECT,
	// CPU side
	input wire logic [13:0] CPU_ADDR,
	input wire logic CPU_ADDR_VALID,
	input wire logic CPU_OPCODE_FETCH,
	input wire logic CPU_QUEUE_END,
	input wire logic CPU_INSTR_BOUNDARY,
	input wire logic CPU_WAIT_STOP,
	input wire logic CPU_MEM_FAIL,
	output logic BG_ACTIVE,
	output logic CPU_WAKE
);

	dsb_pkg::dsb_rx_e rx_state;
	dsb_pkg::dsb_cls_e cls;
	dsb_pkg::dsb_ctrl_s ctrl;
	logic [7:0] cmd_code;
	logic [15:0] rx_value;
	logic [4:0] rx_len;
	logic rx_done;
	logic code_done;
	logic data_done;
	logic [7:0] code_now;
	logic allowed;
	logic [15:0] match;
	logic bg_active;
	logic brk_req;
	logic trace_pending;
	logic enter_bg;
	logic bg_cmd;
	logic leave_bg;
	logic ws_latch;
	logic ws_status;
	logic wait_stop_failure;
	logic [7:0] status_byte;
	logic [15:0] tx_shift;
	logic [4:0] tx_left;

	// Frame decode strobes
	assign code_done = rx_done && rx_state == dsb_pkg::RX_CODE;
	assign data_done = rx_done && rx_state == dsb_pkg::RX_DATA;
	assign code_now = rx_value[7:0];
	assign cls = dsb_pkg::classify(code_now);

	// Intrusive codes need debug mode, unknown codes never run, the rest run any time
	assign allowed = cls == dsb_pkg::CLS_MEM || // R15
		cls == dsb_pkg::CLS_FREE ||
		(cls == dsb_pkg::CLS_ACTIVE && bg_active);

	// Data length follows the command that opened the frame
	always_comb begin
		rx_len = dsb_pkg::LEN_BYTE;
		if (rx_state == dsb_pkg::RX_DATA &&
			cmd_code == dsb_pkg::CMD_MATCH_WRITE) begin
			rx_len = dsb_pkg::LEN_WORD;
		end
	end

	// Host bits are collected MSB first
	dsb_shift #(
		.WIDTH(dsb_pkg::MATCH_W),
		.CNT_W(dsb_pkg::LEN_W)
	) u_rx (
		.clk(SYS_CLK),
		.srst(SRST),
		.clear(SOFT_RESET || rx_state == dsb_pkg::RX_PASS), // R16
		.length(rx_len),
		.bit_valid(RX_BIT_VALID),
		.bit_in(RX_BIT),
		.value(rx_value),
		.done(rx_done)
	);

	// Framing: bits of forwarded or refused frames are not ours
	always_ff @(posedge SYS_CLK) begin
		if (SRST || SOFT_RESET) begin
			rx_state <= dsb_pkg::RX_CODE;
		end else begin
			case (rx_state)
				dsb_pkg::RX_CODE: begin
					if (code_done) begin
						if (code_now == dsb_pkg::CMD_CONTROL_WRITE ||
							code_now == dsb_pkg::CMD_MATCH_WRITE) begin
							rx_state <= dsb_pkg::RX_DATA; // R20
						end else if (cls != dsb_pkg::CLS_LOCAL) begin
							rx_state <= dsb_pkg::RX_PASS;
						end
					end
				end
				dsb_pkg::RX_DATA: begin
					if (rx_done) begin
						rx_state <= dsb_pkg::RX_CODE;
					end
				end
				dsb_pkg::RX_PASS: begin
					if (FWD_DONE) begin
						rx_state <= dsb_pkg::RX_CODE;
					end
				end
				default: rx_state <= dsb_pkg::RX_CODE;
			endcase
		end
	end

	// Code of the frame in progress
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			cmd_code <= dsb_pkg::SCR_ZERO;
		end else if (code_done) begin
			cmd_code <= code_now;
		end
	end

	// Control fields; writable only through the serial control write
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			ctrl.permit <= dsb_pkg::PERMIT_RST; // R02
			ctrl.bkpt_en <= dsb_pkg::BKPT_EN_RST;
			ctrl.force_tag <= dsb_pkg::FORCE_TAG_RST;
		end else if (data_done &&
			cmd_code == dsb_pkg::CMD_CONTROL_WRITE) begin // R17 R20
			// Permit only rises, and never from within debug mode
			if (!bg_active) begin // R19
				ctrl.permit <= ctrl.permit ||
					rx_value[dsb_pkg::BIT_PERMIT]; // R02
			end
			ctrl.bkpt_en <= rx_value[dsb_pkg::BIT_BKPT_EN];
			ctrl.force_tag <= rx_value[dsb_pkg::BIT_FORCE_TAG];
		end
	end

	// Match register, accepted in either mode
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			match <= dsb_pkg::MATCH_RST;
		end else if (data_done &&
			cmd_code == dsb_pkg::CMD_MATCH_WRITE) begin // R14
			match <= rx_value; // R13
		end
	end

	dsb_bkpt u_bkpt (
		.clk(SYS_CLK),
		.srst(SRST),
		.ctrl(ctrl),
		.match_addr(match[dsb_pkg::ADDR_W-1:0]),
		.halted(bg_active),
		.cpu_addr(CPU_ADDR),
		.addr_valid(CPU_ADDR_VALID),
		.opcode_fetch(CPU_OPCODE_FETCH),
		.queue_end(CPU_QUEUE_END),
		.instr_boundary(CPU_INSTR_BOUNDARY),
		.break_req(brk_req)
	);

	// Mode entry: background works even in wait/stop
	assign bg_cmd = code_done && code_now == dsb_pkg::CMD_BACKGROUND;
	assign enter_bg = ctrl.permit && // R01 R21
		(bg_cmd || brk_req || // R08 R09
		(trace_pending && CPU_INSTR_BOUNDARY));
	assign leave_bg = code_done && allowed && bg_active &&
		(code_now == dsb_pkg::CMD_GO || code_now == dsb_pkg::CMD_TRACE);

	// Active debug mode; an entry beats a leave in the same cycle
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			bg_active <= 1'b0;
		end else if (enter_bg) begin // R01
			bg_active <= 1'b1; // R03
		end else if (leave_bg) begin
			bg_active <= 1'b0; // R03
		end
	end

	// Single step returns after one instruction boundary
	always_ff @(posedge SYS_CLK) begin
		if (SRST || enter_bg) begin
			trace_pending <= 1'b0;
		end else if (leave_bg && code_now == dsb_pkg::CMD_TRACE) begin
			trace_pending <= 1'b1;
		end
	end

	// Wakeup pulse and memory of having left wait/stop
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			CPU_WAKE <= 1'b0;
			ws_latch <= 1'b0;
		end else begin
			CPU_WAKE <= enter_bg && bg_cmd && CPU_WAIT_STOP; // R09
			if (enter_bg && CPU_WAIT_STOP) begin
				ws_latch <= 1'b1; // R07
			end else if (leave_bg) begin
				ws_latch <= 1'b0;
			end
		end
	end
	assign ws_status = CPU_WAIT_STOP || ws_latch; // R07

	// Failure flag; a new failure wins over the clearing command
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			wait_stop_failure <= 1'b0;
		end else if (CPU_MEM_FAIL) begin
			wait_stop_failure <= 1'b1; // R11
		end else if (code_done && cls == dsb_pkg::CLS_MEM) begin
			wait_stop_failure <= 1'b0;
		end
	end

	// Status byte; undescribed bits stay zero
	always_comb begin
		status_byte = dsb_pkg::SCR_ZERO; // R22
		status_byte[dsb_pkg::BIT_PERMIT] = ctrl.permit;
		status_byte[dsb_pkg::BIT_ACTIVE] = bg_active; // R03
		status_byte[dsb_pkg::BIT_BKPT_EN] = ctrl.bkpt_en;
		status_byte[dsb_pkg::BIT_FORCE_TAG] = ctrl.force_tag;
		status_byte[dsb_pkg::BIT_WS] = ws_status; // R07
		status_byte[dsb_pkg::BIT_WSF] = wait_stop_failure; // R11
	end

	// Reply shifter; the MSB is always on the wire
	always_ff @(posedge SYS_CLK) begin
		if (SRST || SOFT_RESET) begin
			tx_shift <= dsb_pkg::MATCH_RST;
			tx_left <= dsb_pkg::LEN_NONE;
			TX_BUSY <= 1'b0;
		end else if (code_done &&
			code_now == dsb_pkg::CMD_STATUS_READ) begin // R17 R20
			tx_shift <= {status_byte, dsb_pkg::SCR_ZERO};
			tx_left <= dsb_pkg::LEN_BYTE;
			TX_BUSY <= 1'b1;
		end else if (code_done &&
			code_now == dsb_pkg::CMD_MATCH_READ) begin // R14
			tx_shift <= match;
			tx_left <= dsb_pkg::LEN_WORD;
			TX_BUSY <= 1'b1;
		end else if (TX_BIT_REQ && tx_left != dsb_pkg::LEN_NONE) begin
			tx_shift <= {tx_shift[14:0], 1'b0}; // R16
			tx_left <= tx_left - 1'b1;
			TX_BUSY <= tx_left != 5'h01;
		end
	end
	assign TX_BIT = tx_shift[15];

	// Forwarding and refusal, one-cycle pulses
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			FWD_VALID <= 1'b0;
			FWD_CODE <= dsb_pkg::SCR_ZERO;
			CMD_REJECT <= 1'b0;
		end else begin
			FWD_VALID <= code_done && allowed; // R15
			CMD_REJECT <= code_done && !allowed && // R15
				cls != dsb_pkg::CLS_LOCAL;
			if (code_done) begin
				FWD_CODE <= code_now;
			end
		end
	end
	assign BG_ACTIVE = bg_active;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	permit_gate_a: assert property ( // R01
		!ctrl.permit && !bg_active |=> !bg_active)
		else $error("debug mode entered without permit");

	permit_sticky_a: assert property ( // R02
		ctrl.permit |=> ctrl.permit)
		else $error("permit bit dropped without reset");

	status_active_a: assert property ( // R03
		code_done && code_now == dsb_pkg::CMD_STATUS_READ
		|=> tx_shift[14] == $past(bg_active) && TX_BUSY)
		else $error("status reply shows wrong active bit");

	status_zero_a: assert property ( // R22
		code_done && code_now == dsb_pkg::CMD_STATUS_READ
		|=> !tx_shift[11] && !tx_shift[8])
		else $error("undescribed status bits not zero");

	bg_enter_a: assert property ( // R21
		bg_cmd && ctrl.permit |=> bg_active ##1 bg_active)
		else $error("background command did not enter debug mode");

	wake_ws_a: assert property ( // R07
		bg_cmd && ctrl.permit && CPU_WAIT_STOP
		|=> CPU_WAKE && ws_status)
		else $error("wakeup from wait/stop not reported");

	fail_set_a: assert property ( // R11
		CPU_MEM_FAIL |=> wait_stop_failure)
		else $error("wait/stop failure not flagged");

	intrusive_gate_a: assert property ( // R15
		code_done && cls == dsb_pkg::CLS_ACTIVE && !bg_active
		|=> CMD_REJECT && !FWD_VALID)
		else $error("intrusive command passed while running");

	match_write_a: assert property ( // R14
		data_done && cmd_code == dsb_pkg::CMD_MATCH_WRITE
		|=> match == $past(rx_value))
		else $error("match register write lost");

	msb_first_a: assert property ( // R16
		TX_BIT_REQ && tx_left > 5'h01 && !code_done && !SOFT_RESET
		|=> TX_BIT == $past(tx_shift[14]))
		else $error("reply not shifted MSB first");

	permit_lock_a: assert property ( // R19
		data_done && cmd_code == dsb_pkg::CMD_CONTROL_WRITE
		&& bg_active && !ctrl.permit |=> !ctrl.permit)
		else $error("permit written inside debug mode");

	status_ro_a: assert property ( // R19
		data_done && cmd_code == dsb_pkg::CMD_CONTROL_WRITE
		&& !enter_bg && !CPU_MEM_FAIL
		|=> bg_active == $past(bg_active) && wait_stop_failure == $past(wait_stop_failure))
		else $error("control write changed a status bit");

	bg_by_cmd_c: cover property (bg_cmd && ctrl.permit ##1 bg_active);
	bg_by_bkpt_c: cover property (brk_req && ctrl.permit ##1 bg_active);
	status_rd_c: cover property (code_done &&
		code_now == dsb_pkg::CMD_STATUS_READ ##[1:40] !TX_BUSY);
	go_c: cover property (leave_bg ##1 !bg_active);

endmodule

// ==== testbench/dsb_host_model.sv ====
/*
 * Behavioural debug host for the single-wire debug core.
 * Assumes a bit-timing front end already turned wire bits into
 * strobes on the bus clock; drives only after rising edges.
 */
`timescale 1ns/1ps
module dsb_host_model (
	// Clock
	input wire logic clk,
	// Host to target
	output logic rx_valid,
	output logic rx_bit,
	output logic soft_reset,
	// Target to host
	input wire logic tx_bit,
	input wire logic tx_busy,
	output logic tx_req
);
	// Idle levels before the first frame
	initial begin
		rx_valid = 1'b0;
		rx_bit = 1'b1;
		soft_reset = 1'b0;
		tx_req = 1'b0;
	end

	// One bit a cycle; line shows inverse of last bit when idle
	task automatic send_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_bit <= v[i];
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_bit <= ~v[0];
	endtask

	// High byte first keeps the word MSB first
	task automatic send_word(input logic [15:0] v);
		send_byte(v[15:8]);
		send_byte(v[7:0]);
	endtask

	// Bounded wait for the reply, then one request per bit
	task automatic recv_byte(output logic [7:0] v);
		int w;
		w = 0;
		v = 8'h00;
		@(posedge clk);
		while (tx_busy !== 1'b1 && w < 10) begin
			@(posedge clk);
			w++;
		end
		for (int i = 0; i < 8; i++) begin
			v = {v[6:0], tx_bit};
			tx_req <= 1'b1;
			@(posedge clk);
			tx_req <= 1'b0;
			@(posedge clk);
		end
	endtask

	task automatic recv_word(output logic [15:0] v);
		recv_byte(v[15:8]);
		recv_byte(v[7:0]);
	endtask

	// Timeout pulse abandons a refused frame
	task automatic abort();
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
	endtask
endmodule

// ==== testbench/testbench.sv ====
/*
 * Self-checking bench for the debug status and breakpoint core.
 * Assumes the host model drives the serial side and that the
 * executing unit finishes each forwarded code one cycle later.
 */
`timescale 1ns/1ps
module testbench;
	logic SYS_CLK, SRST, rx_valid, rx_bit, tx_req, soft_reset;
	logic tx_bit, tx_busy, fwd_done, fwd_valid, cmd_reject;
	logic [7:0] fwd_code;
	logic [13:0] cpu_addr;
	logic cpu_valid, cpu_fetch, cpu_qend, cpu_bnd, cpu_ws, mem_fail;
	logic bg, wake;
	int err_total = 0;
	int comparisons = 0;
	int fwd_cnt = 0;
	int rej_cnt = 0;
	int wake_cnt = 0;

	dsb_core dsb_core_inst (.SYS_CLK(SYS_CLK), .SRST(SRST),
		.RX_BIT_VALID(rx_valid), .RX_BIT(rx_bit), .TX_BIT_REQ(tx_req),
		.SOFT_RESET(soft_reset), .TX_BIT(tx_bit), .TX_BUSY(tx_busy),
		.FWD_DONE(fwd_done), .FWD_VALID(fwd_valid),
		.FWD_CODE(fwd_code), .CMD_REJECT(cmd_reject),
		.CPU_ADDR(cpu_addr), .CPU_ADDR_VALID(cpu_valid),
		.CPU_OPCODE_FETCH(cpu_fetch), .CPU_QUEUE_END(cpu_qend),
		.CPU_INSTR_BOUNDARY(cpu_bnd), .CPU_WAIT_STOP(cpu_ws),
		.CPU_MEM_FAIL(mem_fail), .BG_ACTIVE(bg), .CPU_WAKE(wake));

	dsb_host_model dsb_host_model_inst (.clk(SYS_CLK),
		.rx_valid(rx_valid), .rx_bit(rx_bit), .soft_reset(soft_reset),
		.tx_bit(tx_bit), .tx_busy(tx_busy), .tx_req(tx_req));

	// 40 MHz bus clock
	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end

	// Pulse counters; executing unit answers one cycle late
	always @(posedge SYS_CLK) begin
		if (fwd_valid === 1'b1)
			fwd_cnt++;
		if (cmd_reject === 1'b1)
			rej_cnt++;
		if (wake === 1'b1)
			wake_cnt++;
		fwd_done <= (fwd_valid === 1'b1);
	end

	task automatic results();
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Code-only command; gap covers forward and done handshake
	task automatic cmd(input logic [7:0] code);
		dsb_host_model_inst.send_byte(code);
		repeat (6) @(posedge SYS_CLK);
	endtask

	task automatic wr_ctrl(input logic [7:0] d);
		dsb_host_model_inst.send_byte(dsb_pkg::CMD_CONTROL_WRITE);
		dsb_host_model_inst.send_byte(d);
		repeat (6) @(posedge SYS_CLK);
	endtask

	task automatic rd_status(input logic [7:0] exp);
		logic [7:0] v;
		dsb_host_model_inst.send_byte(dsb_pkg::CMD_STATUS_READ);
		dsb_host_model_inst.recv_byte(v);
		check({8'h00, v}, {8'h00, exp});
		check({15'h0000, tx_busy}, 16'h0000);
		repeat (4) @(posedge SYS_CLK);
	endtask

	task automatic rd_match(input logic [15:0] exp);
		logic [15:0] v;
		dsb_host_model_inst.send_byte(dsb_pkg::CMD_MATCH_READ);
		dsb_host_model_inst.recv_word(v);
		check(v, exp);
		repeat (4) @(posedge SYS_CLK);
	endtask

	// Address hit, then a boundary or a queue-end pulse
	task automatic cpu_hit(input logic fetch, input logic at_bnd);
		@(posedge SYS_CLK);
		cpu_addr <= 14'h1234;
		cpu_valid <= 1'b1;
		cpu_fetch <= fetch;
		@(posedge SYS_CLK);
		cpu_valid <= 1'b0;
		cpu_fetch <= 1'b0;
		cpu_bnd <= at_bnd;
		cpu_qend <= ~at_bnd;
		@(posedge SYS_CLK);
		cpu_bnd <= 1'b0;
		cpu_qend <= 1'b0;
		repeat (4) @(posedge SYS_CLK);
	endtask

	// Hang guard, well beyond the fewer than one thousand cycles needed
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		err_total++;
		results();
	end

	initial begin
		{SRST, fwd_done, cpu_valid, cpu_fetch} = 4'h8;
		{cpu_qend, cpu_bnd, cpu_ws, mem_fail} = 4'h0;
		cpu_addr = 14'h0000;
		repeat (10) @(posedge SYS_CLK);
		SRST <= 1'b0;
		rd_status(8'h00);
		rd_match(16'h0000);
		dsb_host_model_inst.send_byte(dsb_pkg::CMD_MATCH_WRITE);
		dsb_host_model_inst.send_word(16'h1234);
		rd_match(16'h1234);
		cmd(dsb_pkg::CMD_BACKGROUND);
		check({15'h0000, bg}, 16'h0000);
		cmd(dsb_pkg::CMD_GO);
		check(16'(rej_cnt), 16'h0001);
		dsb_host_model_inst.abort();
		wr_ctrl(8'hFF);
		rd_status(8'hB0);
		wr_ctrl(8'h00);
		rd_status(8'h80);
		cpu_hit(1'b1, 1'b1);
		cpu_hit(1'b1, 1'b0);
		check({15'h0000, bg}, 16'h0000);
		wr_ctrl(8'h30);
		cpu_hit(1'b0, 1'b1);
		check({15'h0000, bg}, 16'h0001);
		rd_status(8'hF0);
		wr_ctrl(8'h20);
		rd_status(8'hE0);
		cmd(dsb_pkg::CMD_GO);
		check({15'h0000, bg}, 16'h0000);
		cpu_hit(1'b0, 1'b0);
		check({15'h0000, bg}, 16'h0000);
		cpu_hit(1'b1, 1'b0);
		check({15'h0000, bg}, 16'h0001);
		cmd(dsb_pkg::CMD_GO);
		// Permit stays set before the code may stop
		wr_ctrl(8'h00);
		cpu_ws <= 1'b1;
		rd_status(8'h84);
		cmd(dsb_pkg::CMD_BACKGROUND);
		check(16'(wake_cnt), 16'h0001);
		check({15'h0000, bg}, 16'h0001);
		cpu_ws <= 1'b0;
		rd_status(8'hC4);
		cmd(dsb_pkg::CMD_GO);
		rd_status(8'h80);
		cmd(8'hE0);
		check({8'h00, fwd_code}, 16'h00E0);
		@(posedge SYS_CLK);
		mem_fail <= 1'b1;
		@(posedge SYS_CLK);
		mem_fail <= 1'b0;
		rd_status(8'h82);
		// Recovery: halt, repeat the access, then read the status
		cmd(dsb_pkg::CMD_BACKGROUND);
		cmd(8'hE0);
		rd_status(8'hC0);
		// Single step leaves, then returns at the next boundary
		cmd(dsb_pkg::CMD_TRACE);
		check({15'h0000, bg}, 16'h0000);
		cpu_hit(1'b0, 1'b1);
		check({15'h0000, bg}, 16'h0001);
		cmd(dsb_pkg::CMD_GO);
		check(16'(fwd_cnt), 16'h0007);
		check(16'(rej_cnt), 16'h0001);
		// Mid-run reset must drop the sticky permit and the match word
		SRST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		SRST <= 1'b0;
		rd_status(8'h00);
		rd_match(16'h0000);
		results();
	end
endmodule
